// ### design/cal_regs_pkg.sv
// register constants for the channel 1 calibration bank
// assumes a 6-bit word address and 16-bit register words from the serial port
package cal_regs_pkg;
    localparam logic [5:0]  CH1_OFFSET_HIGH_ADDR = 6'h0F; // offset bits 23:8
    localparam logic [5:0]  CH1_OFFSET_LOW_ADDR  = 6'h10; // offset bits 7:0
    localparam logic [5:0]  CH1_GAIN_HIGH_ADDR   = 6'h11; // gain bits 23:8
    localparam logic [5:0]  CH1_GAIN_LOW_ADDR    = 6'h12; // gain bits 7:0
    localparam logic [5:0]  CHECKSUM_ADDR        = 6'h3E; // map checksum, read only
    localparam logic [5:0]  RESERVED_TOP_ADDR    = 6'h3F; // reserved word
    localparam logic [15:0] OFFSET_HIGH_RESET    = 16'h0000;
    localparam logic [7:0]  OFFSET_LOW_RESET     = 8'h00;
    localparam logic [15:0] GAIN_HIGH_RESET      = 16'h8000;
    localparam logic [7:0]  GAIN_LOW_RESET       = 8'h00;
    localparam logic [15:0] CHECKSUM_RESET       = 16'h0000;
    localparam logic [15:0] RESERVED_RESET       = 16'h0000;
    localparam logic [15:0] CRC_POLY             = 16'h1021; // ccitt polynomial
    localparam logic [15:0] CRC_SEED             = 16'hFFFF; // crc preset
    localparam int          LOW_FIELD_POS        = 8;        // low byte sits in 15:8
    localparam int          CRC_WORDS            = 5;        // covered words
endpackage

// ### design/ch1_cal_regs.sv
// channel 1 offset and gain calibration registers, map checksum, reserved word
// the offset and gain words leave as 24-bit values for the conversion datapath
// low registers keep only their upper byte, the lower byte reads back zero
// assumes the serial port decodes frames into word-wide read and write strobes
// assumes strobes, address and data already sit on core_clk, no resync here
// assumes rst_n release is already aligned to core_clk by the reset tree
`timescale 1ns/1ps
module ch1_cal_regs
    import cal_regs_pkg::*;
(
    input  wire logic        core_clk,   // core clock
    input  wire logic        rst_n,      // async reset, active low
    input  wire logic [5:0]  reg_addr,   // word address from serial port
    input  wire logic        reg_wr,     // write strobe, one cycle
    input  wire logic [15:0] reg_wdata,  // write data
    input  wire logic        reg_rd,     // read strobe, one cycle
    output logic      [15:0] reg_rdata,  // read data, registered
    output logic             reg_hit,    // address belongs to this bank
    output logic      [23:0] ch1_offset, // signed offset word to datapath
    output logic      [23:0] ch1_gain,   // unsigned gain word to datapath
    output logic      [15:0] map_crc     // current map checksum
);
    // link to the serial checksum engine
    crc_link_if link (); // words out, finished checksum back

    // software visible calibration state
    logic [15:0] off_hi_reg;  // ch1_offset_high_word, offset bits 23:8
    logic [15:0] off_hi_next; // next offset high word
    logic [7:0]  off_lo_reg;  // ch1_offset_low_byte, offset bits 7:0
    logic [7:0]  off_lo_next; // next offset low byte
    logic [15:0] gn_hi_reg;   // ch1_gain_high_word, gain bits 23:8
    logic [15:0] gn_hi_next;  // next gain high word
    logic [7:0]  gn_lo_reg;   // ch1_gain_low_byte, gain bits 7:0
    logic [7:0]  gn_lo_next;  // next gain low byte
    logic [15:0] rsvd_reg;    // reserved top word, kept as written
    logic [15:0] rsvd_next;   // next reserved word

    // checksum restart state
    logic        start_reg;   // restart checksum pass, one-cycle pulse
    logic        start_next;  // a covered word changes this cycle

    // checksum as software sees it
    logic [15:0] crc_reg;     // checksum as read
    logic [15:0] crc_next;    // next checksum value

    // read side state
    logic [15:0] rd_reg;      // read data holding
    logic [15:0] rd_next;     // next read data
    logic [15:0] rd_mux;      // word selected by the address

    // write path for software registers
    // a write only touches the addressed word, every other word holds
    // a read in the same cycle still returns the old word
    always_comb begin
        off_hi_next = off_hi_reg; // hold by default
        off_lo_next = off_lo_reg; // hold by default
        gn_hi_next  = gn_hi_reg;  // hold by default
        gn_lo_next  = gn_lo_reg;  // hold by default
        rsvd_next   = rsvd_reg;   // hold by default
        if (reg_wr) begin // write strobe taken this edge
            unique case (reg_addr)
                CH1_OFFSET_HIGH_ADDR: begin // full word
                    off_hi_next = reg_wdata;
                end
                CH1_OFFSET_LOW_ADDR: begin // upper byte only
                    off_lo_next = reg_wdata[15:LOW_FIELD_POS];
                end
                CH1_GAIN_HIGH_ADDR: begin // full word
                    gn_hi_next = reg_wdata;
                end
                CH1_GAIN_LOW_ADDR: begin // upper byte only
                    gn_lo_next = reg_wdata[15:LOW_FIELD_POS];
                end
                RESERVED_TOP_ADDR: begin // stored as written
                    rsvd_next = reg_wdata;
                end
                default: begin // checksum and others ignore writes
                end
            endcase
        end
    end

    // change detector for the covered words
    // only a real change restarts the engine, so rewriting the same value
    // does not push the checksum out by another full pass
    always_comb begin
        start_next = 1'b0; // no restart unless a word moves
        if (off_hi_next != off_hi_reg) begin // offset high moved
            start_next = 1'b1;
        end
        if (off_lo_next != off_lo_reg) begin // offset low moved
            start_next = 1'b1;
        end
        if (gn_hi_next != gn_hi_reg) begin // gain high moved
            start_next = 1'b1;
        end
        if (gn_lo_next != gn_lo_reg) begin // gain low moved
            start_next = 1'b1;
        end
        if (rsvd_next != rsvd_reg) begin // reserved word moved
            start_next = 1'b1;
        end
    end

    // checksum holds the last finished pass
    // a pass cut short by a restart never publishes its result
    always_comb begin
        crc_next = crc_reg; // hold between passes
        if (link.done) begin // engine finished a full pass
            crc_next = link.result;
        end
    end

    // read select, low registers read back zero in 7:0
    // the hit flag follows the address alone, strobe or not
    always_comb begin
        rd_mux  = 16'h0000; // unmapped reads return zero
        reg_hit = 1'b1;     // assume a bank address
        unique case (reg_addr)
            CH1_OFFSET_HIGH_ADDR: begin // offset bits 23:8
                rd_mux = off_hi_reg;
            end
            CH1_OFFSET_LOW_ADDR: begin // offset bits 7:0 in 15:8
                rd_mux = {off_lo_reg, 8'h00};
            end
            CH1_GAIN_HIGH_ADDR: begin // gain bits 23:8
                rd_mux = gn_hi_reg;
            end
            CH1_GAIN_LOW_ADDR: begin // gain bits 7:0 in 15:8
                rd_mux = {gn_lo_reg, 8'h00};
            end
            CHECKSUM_ADDR: begin // device written only
                rd_mux = crc_reg;
            end
            RESERVED_TOP_ADDR: begin // reads back as written
                rd_mux = rsvd_reg;
            end
            default: begin // not this bank, reads zero
                reg_hit = 1'b0;
            end
        endcase
    end

    // read data capture, held until the next read strobe
    // the port can shift the word out at leisure after one cycle
    always_comb begin
        rd_next = rd_reg; // hold last read word
        if (reg_rd) begin // read strobe taken this edge
            rd_next = rd_mux;
        end
    end

    // software register state
    // async reset, every word returns to its documented default
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            off_hi_reg <= OFFSET_HIGH_RESET;
            off_lo_reg <= OFFSET_LOW_RESET;
            gn_hi_reg  <= GAIN_HIGH_RESET; // midpoint gain
            gn_lo_reg  <= GAIN_LOW_RESET;
            rsvd_reg   <= RESERVED_RESET;
        end else begin
            off_hi_reg <= off_hi_next;
            off_lo_reg <= off_lo_next;
            gn_hi_reg  <= gn_hi_next;
            gn_lo_reg  <= gn_lo_next;
            rsvd_reg   <= rsvd_next;
        end
    end

    // restart pulse register
    // one cycle after the changing write, the engine sees the new words
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_reg <= 1'b0;
        end else begin
            start_reg <= start_next;
        end
    end

    // published checksum register
    // stays zero after reset until the first pass that no restart cuts short completes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_reg <= CHECKSUM_RESET;
        end else begin
            crc_reg <= crc_next;
        end
    end

    // read data register
    // clears on reset so the port never shifts an unknown word
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_reg <= 16'h0000;
        end else begin
            rd_reg <= rd_next;
        end
    end

    // covered words feed the engine in map order, low bytes as read
    assign link.start    = start_reg;
    assign link.words[0] = off_hi_reg;
    assign link.words[1] = {off_lo_reg, 8'h00};
    assign link.words[2] = gn_hi_reg;
    assign link.words[3] = {gn_lo_reg, 8'h00};
    assign link.words[4] = rsvd_reg;

    // serial checksum engine, one message bit per clock
    crc_engine u_crc (
        .core_clk (core_clk), // shared core clock
        .rst_n    (rst_n),    // shared reset
        .link     (link)      // words out, checksum back
    );

    // datapath words, high register above the low byte
    assign ch1_offset = {off_hi_reg, off_lo_reg}; // signed
    assign ch1_gain   = {gn_hi_reg, gn_lo_reg};   // unsigned
    assign map_crc    = crc_reg;                  // same word as read at the checksum address
    assign reg_rdata  = rd_reg;                   // registered read data
endmodule

// ### design/crc_engine.sv
// serial crc16 over five 16-bit words, one bit per clock
// assumes the bank holds words steady while busy or restarts it
`timescale 1ns/1ps
module crc_engine
    import cal_regs_pkg::*;
(
    input wire logic core_clk, // core clock
    input wire logic rst_n,    // async reset, active low
    crc_link_if.engine link    // words in, checksum out
);
    logic [15:0] acc_reg, acc_next;     // running crc
    logic [6:0]  bit_reg, bit_next;     // bit counter over 80 bits
    logic        busy_reg, busy_next;   // pass in progress
    logic [15:0] res_reg, res_next;     // published result
    logic        done_reg, done_next;   // done pulse
    logic        din;                   // current message bit
    // pick message bit, msb first per word
    always_comb begin
        din = link.words[bit_reg[6:4]][4'd15 - bit_reg[3:0]];
    end
    // next-state for the shift engine
    always_comb begin
        acc_next  = acc_reg;
        bit_next  = bit_reg;
        busy_next = busy_reg;
        res_next  = res_reg;
        done_next = 1'b0;
        if (link.start) begin // restart on any change
            acc_next  = CRC_SEED;
            bit_next  = 7'h00;
            busy_next = 1'b1;
        end else if (busy_reg) begin
            acc_next = {acc_reg[14:0], 1'b0} ^ ((acc_reg[15] ^ din) ? CRC_POLY : 16'h0000);
            if (bit_reg == 7'(CRC_WORDS * 16 - 1)) begin // last bit
                busy_next = 1'b0;
                res_next  = {acc_reg[14:0], 1'b0} ^ ((acc_reg[15] ^ din) ? CRC_POLY : 16'h0000);
                done_next = 1'b1;
            end else begin
                bit_next = bit_reg + 7'h01;
            end
        end
    end
    // register state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg  <= CRC_SEED;
            bit_reg  <= 7'h00;
            busy_reg <= 1'b0;
            res_reg  <= CHECKSUM_RESET;
            done_reg <= 1'b0;
        end else begin
            acc_reg  <= acc_next;
            bit_reg  <= bit_next;
            busy_reg <= busy_next;
            res_reg  <= res_next;
            done_reg <= done_next;
        end
    end
    assign link.result = res_reg;
    assign link.done   = done_reg;
endmodule

// ### design/crc_link_if.sv
// carries covered register words to the checksum engine and its result back
// assumes both ends on core_clk
`timescale 1ns/1ps
interface crc_link_if;
    logic        start;    // begin a new pass, one-cycle pulse
    logic [15:0] words [5]; // covered words, driven live from the bank registers
    logic [15:0] result;   // finished checksum
    logic        done;     // result updated, one-cycle pulse
    modport bank (output start, output words, input result, input done);
    modport engine (input start, input words, output result, output done);
endinterface

// ### tb/ch1_cal_regs_properties.sv
// port assertions for the channel 1 calibration bank
// assumes binding into ch1_cal_regs, one clock domain
`timescale 1ns/1ps
module ch1_cal_regs_properties
    import cal_regs_pkg::*;
(
    input wire logic        core_clk,   // clock
    input wire logic        rst_n,      // reset, active low
    input wire logic [5:0]  reg_addr,   // word address
    input wire logic        reg_wr,     // write strobe
    input wire logic [15:0] reg_wdata,  // write data
    input wire logic        reg_rd,     // read strobe
    input wire logic [15:0] reg_rdata,  // read data
    input wire logic        reg_hit,    // bank hit
    input wire logic [23:0] ch1_offset, // offset word
    input wire logic [23:0] ch1_gain,   // gain word
    input wire logic [15:0] map_crc     // checksum
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // a write or a read taken at one address
    sequence wr_at(logic [5:0] a); reg_wr && reg_addr == a; endsequence
    sequence rd_at(logic [5:0] a); reg_rd && !reg_wr && reg_addr == a; endsequence
    a_offset_low_zero: assert property (
        rd_at(CH1_OFFSET_LOW_ADDR) |=> reg_rdata[7:0] == 8'h00) else $error("offset low byte not zero");
    a_gain_high_wr: assert property (
        wr_at(CH1_GAIN_HIGH_ADDR) |=> ch1_gain[23:8] == $past(reg_wdata)) else $error("gain high not stored");
    a_gain_reset_mid: assert property (
        $rose(rst_n) |-> ch1_gain == 24'h800000) else $error("gain reset value wrong");
    a_gain_low_byte: assert property (
        wr_at(CH1_GAIN_LOW_ADDR) |=> ch1_gain[7:0] == $past(reg_wdata[15:8])) else $error("gain low byte wrong");
    a_crc_read_back: assert property (
        rd_at(CHECKSUM_ADDR) |=> reg_rdata == $past(map_crc)) else $error("checksum read differs");
    a_offset_high_wr: assert property (
        wr_at(CH1_OFFSET_HIGH_ADDR) |=> ch1_offset[23:8] == $past(reg_wdata)) else $error("offset high not stored");
    a_crc_restart_hold: assert property (
        wr_at(CH1_GAIN_HIGH_ADDR) ##0 reg_wdata != ch1_gain[23:8] |=> $stable(map_crc) [*8])
        else $error("checksum moved too early");
endmodule
bind ch1_cal_regs ch1_cal_regs_properties u_ch1_cal_regs_properties (.core_clk, .rst_n, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .reg_hit, .ch1_offset, .ch1_gain, .map_crc);

// ### tb/host_model.sv
// host side of the word-wide register port
// assumes strobes are taken on the rising edge of core_clk
`timescale 1ns/1ps
module host_model (
    input  wire logic        core_clk,  // clock
    output logic      [5:0]  reg_addr,  // word address
    output logic             reg_wr,    // write strobe
    output logic      [15:0] reg_wdata, // write data
    output logic             reg_rd,    // read strobe
    input  wire logic [15:0] reg_rdata  // read data
);
    // idle bus at time zero
    initial begin
        reg_addr = 6'h00;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
        reg_rd = 1'b0;
    end
    // one-cycle write, data scrambled once released
    task automatic write_word(input logic [5:0] a, input logic [15:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    // one-cycle read, word taken once registered
    task automatic read_word(input logic [5:0] a, output logic [15:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
endmodule

// ### tb/tb.sv
// self-checking bench for the channel 1 calibration bank
// assumes host_model drives the register port
`timescale 1ns/1ps
module tb;
    logic        core_clk = 1'b0;          // 200 MHz clock
    logic        rst_n = 1'b0;             // reset, active low
    logic [5:0]  reg_addr;                 // host address
    logic        reg_wr, reg_rd, reg_hit;  // strobes and hit
    logic [15:0] reg_wdata, reg_rdata, rd; // data words
    logic [23:0] ch1_offset, ch1_gain;     // datapath words
    logic [15:0] map_crc;                  // checksum
    int          err_total = 0;            // mismatches
    int          total_checks = 0;         // comparisons
    logic [5:0]  ra [6] = '{6'h0F, 6'h10, 6'h11, 6'h12, 6'h3E, 6'h3F};                       // bank addresses
    logic [15:0] rv [6] = '{16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000}; // reset words
    always #2.5 core_clk = ~core_clk;
    host_model u_host_model (.core_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
    ch1_cal_regs u_ch1_cal_regs (.core_clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
        .reg_hit, .ch1_offset, .ch1_gain, .map_crc);
    // compare and count
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // read a word and compare
    task automatic rd_chk(input string name, input logic [5:0] a, input logic [15:0] exp);
        u_host_model.read_word(a, rd);
        check(name, {8'h00, rd}, {8'h00, exp});
    endtask
    // reference checksum, msb first
    function automatic logic [15:0] crc_ref(input logic [79:0] d);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 79; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction
    // counts then verdict
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // watchdog, far beyond the sequence length
    initial begin
        #20000;
        err_total++;
        summarize();
    end
    // main sequence
    initial begin
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        for (int i = 0; i < 6; i++) rd_chk("reset word", ra[i], rv[i]);
        check("gain port", ch1_gain, 24'h800000);
        check("crc port reset", {8'h00, map_crc}, 24'h000000);
        $display("test reset done");
        u_host_model.write_word(6'h0F, 16'hA5C3);
        u_host_model.write_word(6'h10, 16'h7EFF);
        u_host_model.write_word(6'h11, 16'h1234);
        u_host_model.write_word(6'h12, 16'hBCDE);
        rd_chk("offset low", 6'h10, 16'h7E00);
        rd_chk("gain low", 6'h12, 16'hBC00);
        rd_chk("gain high", 6'h11, 16'h1234);
        check("hit mapped", {23'h0, reg_hit}, 24'h000001);
        check("offset port", ch1_offset, 24'hA5C37E);
        check("gain port", ch1_gain, 24'h1234BC);
        $display("test calibration done");
        u_host_model.write_word(6'h3E, 16'hFFFF);
        u_host_model.write_word(6'h3F, 16'h0000);
        u_host_model.write_word(6'h20, 16'h5555);
        rd_chk("unmapped", 6'h20, 16'h0000);
        check("hit", {23'h0, reg_hit}, 24'h0);
        repeat (90) @(negedge core_clk);
        check("crc port", map_crc, crc_ref(80'hA5C3_7E00_1234_BC00_0000));
        rd_chk("crc word", 6'h3E, crc_ref(80'hA5C3_7E00_1234_BC00_0000));
        u_host_model.write_word(6'h11, 16'h0001);
        repeat (90) @(negedge core_clk);
        check("crc update", map_crc, crc_ref(80'hA5C3_7E00_0001_BC00_0000));
        $display("test checksum done");
        summarize();
    end
endmodule
